// ==== src/sfcal_defines.svh ====
`ifndef SFCAL_DEFINES_SVH
`define SFCAL_DEFINES_SVH

// ==========================================================================
// Register map, byte addresses on the AXI4-Lite port
`define SFCAL_ADDR_MODE      8'h00
`define SFCAL_ADDR_FILTER    8'h04
`define SFCAL_ADDR_STATUS    8'h08
`define SFCAL_ADDR_DATA      8'h0C
`define SFCAL_ADDR_GAIN0     8'h10
`define SFCAL_ADDR_GAIN1     8'h14

// ==========================================================================
// Operating mode encodings
`define SFCAL_MD_IDLE        3'h0
`define SFCAL_MD_CONT        3'h1
`define SFCAL_MD_SINGLE      3'h2
`define SFCAL_MD_SYS_FS      3'h7

// ==========================================================================
// Reset values
`define SFCAL_MODE_RST       7'h00
`define SFCAL_RATE_RST       12'h010
`define SFCAL_CHOP_RST       1'h1
`define SFCAL_GAIN_RST       24'h800000
`define SFCAL_DATA_RST       24'h000000

// ==========================================================================
// Timing counts
`define SFCAL_MOD_DIV        6'h20
`define SFCAL_CAL_PER_CHOP   5'h16
`define SFCAL_CAL_PER_NOCHOP 5'h18

// ==========================================================================
// Full-scale acceptance limits, 1.05 x nominal, in microvolt codes
`define SFCAL_FS_LIM_10MV    24'h002904
`define SFCAL_FS_LIM_20MV    24'h005208
`define SFCAL_FS_LIM_40MV    24'h00A410
`define SFCAL_FS_LIM_80MV    24'h014820

// ==========================================================================
// Data path slicing and bus responses
`define SFCAL_PROD_LSB       23
`define SFCAL_PROD_MSB       46
`define SFCAL_RESP_OKAY      2'h0
`define SFCAL_RESP_SLVERR    2'h2

`endif

// ==== src/sfcal_pkg.sv ====
package sfcal_pkg;

   // =======================================================================
   // Controller states, Gray coded along idle, arm, calibrate
   typedef enum logic [1:0] {
      SFCAL_IDLE = 2'h0,
      SFCAL_ARM  = 2'h1,
      SFCAL_CAL  = 2'h3
   } sfcal_state_t;

   // =======================================================================
   // Mode register, low seven bits of the word
   typedef struct packed {
      logic channel;
      logic ac_excitation_select;
      logic input_range_bit1;
      logic input_range_bit0;
      logic operating_mode_bit2;
      logic operating_mode_bit1;
      logic operating_mode_bit0;
   } sfcal_mode_t;

   // Filter register: rate divider above the chop bit.
   typedef struct packed {
      logic [11:0] rate_div;
      logic        chop_enable;
   } sfcal_filter_t;

   // Status register, read only.
   typedef struct packed {
      sfcal_state_t state;
      logic         gain_cal1;
      logic         gain_cal0;
      logic         range_err;
      logic         ready_n;
   } sfcal_status_t;

   // Control bundle toward the analog front end.
   typedef struct packed {
      logic [1:0] pga_range;
      logic       ac_excitation;
      logic       chop_phase;
      logic       channel;
      logic       cal_active;
   } sfcal_afe_ctl_t;

endpackage : sfcal_pkg

// ==== src/sfcal_rate_div.sv ====
`timescale 1ns/100ps

// ==========================================================================
// Enable-pulse divider: one tick every period enabled cycles.
module sfcal_rate_div #(
   parameter int W = 6
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         clr,
   input  wire logic         en,
   input  wire logic [W-1:0] period,
   output logic              tick
);
   logic [W-1:0] cnt_q;
   logic         last;

   // A period of zero behaves as one so the divider never stalls.
   assign last = (cnt_q >= period - W'(1)) || (period == '0);
   assign tick = en && last && !clr;

   always_ff @(posedge aclk)
   begin
      if (!aresetn || clr)
      begin
         cnt_q <= '0;
      end
      else if (en)
      begin
         cnt_q <= last ? '0 : cnt_q + W'(1);
      end
   end
endmodule : sfcal_rate_div

// ==== src/sfcal_ctrl.sv ====
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "sfcal_defines.svh"

module sfcal_ctrl
   import sfcal_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [23:0] afe_sample,
   output logic             ready_n,
   output sfcal_afe_ctl_t   afe_ctl,
   output logic             mclk_out
);

   localparam int MOD_WAIT = 34;

   // ======================================================================
   // Register state
   sfcal_state_t  state_q;
   sfcal_mode_t   mode_q;
   sfcal_filter_t filt_q;
   logic [23:0]   gain_q [2];
   logic [23:0]   data_q;
   logic [1:0]    gain_cal_q;
   logic          range_err_q;
   logic          ready_n_q;
   logic          chop_ph_q;
   logic [4:0]    per_cnt_q;
   sfcal_afe_ctl_t afe_q;

   logic          aw_hold_q;
   logic          w_hold_q;
   logic [7:0]    awaddr_q;
   logic [31:0]   wdata_q;
   logic [3:0]    wstrb_q;
   logic          bvalid_q;
   logic [1:0]    bresp_q;
   logic          rvalid_q;
   logic [31:0]   rdata_q;
   logic [1:0]    rresp_q;

   logic          mod_tick;
   logic          out_tick;
   logic          cal_start;
   logic          cal_done;
   logic          wr_fire;
   logic          wr_mode;
   logic          cal_cmd;
   logic          conv_upd;
   logic [2:0]    md;
   logic [4:0]    cal_target;
   logic [23:0]   fs_limit;
   logic [47:0]   prod;
   logic [31:0]   mode_new;
   logic [31:0]   filt_new;
   logic [31:0]   gain0_new;
   logic [31:0]   gain1_new;

   function automatic logic [31:0] sfcal_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : sfcal_merge

   // ======================================================================
   // Time base: modulator rate is the master clock over 32, and the output
   // rate divides that again, so every duration follows the clock.
   assign mclk_out = aclk;

   sfcal_rate_div #(.W(6)) u_mod_div (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clr     (1'b0),
      .en      (1'b1),
      .period  (`SFCAL_MOD_DIV),
      .tick    (mod_tick)
   );

   // Restarting the output divider at calibration start keeps the
   // calibration an exact number of output periods.
   sfcal_rate_div #(.W(12)) u_out_div (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clr     (cal_start),
      .en      (mod_tick),
      .period  (filt_q.rate_div),
      .tick    (out_tick)
   );

   // ======================================================================
   // AXI4-Lite slave
   assign s_axi_awready = !aw_hold_q && !bvalid_q;
   assign s_axi_wready  = !w_hold_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   assign wr_fire  = aw_hold_q && w_hold_q && !bvalid_q;
   assign wr_mode  = wr_fire && (awaddr_q == `SFCAL_ADDR_MODE);
   assign mode_new = sfcal_merge({25'h0000000, mode_q}, wdata_q, wstrb_q);
   assign filt_new = sfcal_merge({19'h00000, filt_q}, wdata_q, wstrb_q);
   assign gain0_new = sfcal_merge({8'h00, gain_q[0]}, wdata_q, wstrb_q);
   assign gain1_new = sfcal_merge({8'h00, gain_q[1]}, wdata_q, wstrb_q);
   // Mode writes are refused while a calibration is armed or running.
   assign cal_cmd  = wr_mode && (state_q == SFCAL_IDLE)
                     && (mode_new[2:0] == `SFCAL_MD_SYS_FS);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `SFCAL_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            case (awaddr_q)
               `SFCAL_ADDR_MODE, `SFCAL_ADDR_FILTER,
               `SFCAL_ADDR_GAIN0, `SFCAL_ADDR_GAIN1: bresp_q <= `SFCAL_RESP_OKAY;
               default:                               bresp_q <= `SFCAL_RESP_SLVERR;
            endcase
         end
         else if (bvalid_q && s_axi_bready)
         begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= `SFCAL_RESP_OKAY;
      end
      else if (s_axi_arvalid && !rvalid_q)
      begin
         rvalid_q <= 1'b1;
         rresp_q  <= `SFCAL_RESP_OKAY;
         case (s_axi_araddr)
            `SFCAL_ADDR_MODE:   rdata_q <= {25'h0000000, mode_q};
            `SFCAL_ADDR_FILTER: rdata_q <= {19'h00000, filt_q};
            `SFCAL_ADDR_STATUS: rdata_q <= {26'h0000000, state_q, gain_cal_q,
                                            range_err_q, ready_n_q};
            `SFCAL_ADDR_DATA:   rdata_q <= {8'h00, data_q};
            `SFCAL_ADDR_GAIN0:  rdata_q <= {8'h00, gain_q[0]};
            `SFCAL_ADDR_GAIN1:  rdata_q <= {8'h00, gain_q[1]};
            default:
            begin
               rdata_q <= 32'h00000000;
               rresp_q <= `SFCAL_RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid_q && s_axi_rready)
      begin
         rvalid_q <= 1'b0;
      end
   end

   // ======================================================================
   // Calibration sequencer
   assign md         = mode_q[2:0];
   assign cal_start  = (state_q == SFCAL_ARM) && mod_tick;
   assign cal_target = filt_q.chop_enable ? `SFCAL_CAL_PER_CHOP
                                          : `SFCAL_CAL_PER_NOCHOP;
   assign cal_done   = (state_q == SFCAL_CAL) && out_tick
                       && (per_cnt_q + 5'h01 == cal_target);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q   <= SFCAL_IDLE;
         per_cnt_q <= 5'h00;
      end
      else
      begin
         case (state_q)
            SFCAL_IDLE:
            begin
               per_cnt_q <= 5'h00;
               if (cal_cmd)
               begin
                  state_q <= SFCAL_ARM;
               end
            end
            SFCAL_ARM:
            begin
               if (cal_start)
               begin
                  state_q <= SFCAL_CAL;
               end
            end
            SFCAL_CAL:
            begin
               if (cal_done)
               begin
                  state_q <= SFCAL_IDLE;
               end
               else if (out_tick)
               begin
                  per_cnt_q <= per_cnt_q + 5'h01;
               end
            end
            default: state_q <= SFCAL_IDLE;
         endcase
      end
   end

   // Mode register: hardware returns to idle after a calibration or a
   // single conversion; a host write in the same cycle as the conversion is the newer order.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mode_q <= `SFCAL_MODE_RST;
      end
      else if (wr_mode && (state_q == SFCAL_IDLE))
      begin
         mode_q <= mode_new[6:0];
      end
      else if (cal_done || (conv_upd && (md == `SFCAL_MD_SINGLE)))
      begin
         mode_q[2:0] <= `SFCAL_MD_IDLE;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         filt_q <= {`SFCAL_RATE_RST, `SFCAL_CHOP_RST};
      end
      else if (wr_fire && (awaddr_q == `SFCAL_ADDR_FILTER))
      begin
         filt_q <= filt_new[12:0];
      end
   end

   // ======================================================================
   // Ready line
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ready_n_q <= 1'b1;
      end
      else if (cal_start)
      begin
         ready_n_q <= 1'b1;
      end
      else if (cal_done || conv_upd)
      begin
         ready_n_q <= 1'b0;
      end
   end
   assign ready_n = ready_n_q;

   // ======================================================================
   // Coefficients: the point taken at the last period of the calibration is
   // checked against the range limit before it may replace the gain.
   always_comb
   begin
      case ({mode_q.input_range_bit1, mode_q.input_range_bit0})
         2'h0:    fs_limit = `SFCAL_FS_LIM_10MV;
         2'h1:    fs_limit = `SFCAL_FS_LIM_20MV;
         2'h2:    fs_limit = `SFCAL_FS_LIM_40MV;
         default: fs_limit = `SFCAL_FS_LIM_80MV;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         gain_q[0]   <= `SFCAL_GAIN_RST;
         gain_q[1]   <= `SFCAL_GAIN_RST;
         gain_cal_q  <= 2'h0;
         range_err_q <= 1'b0;
      end
      else if (cal_start)
      begin
         range_err_q <= 1'b0;
      end
      else if (cal_done)
      begin
         if (afe_sample <= fs_limit)
         begin
            gain_q[mode_q.channel]     <= afe_sample;
            gain_cal_q[mode_q.channel] <= 1'b1;
         end
         else
         begin
            range_err_q <= 1'b1;
         end
      end
      else if (wr_fire && (state_q == SFCAL_IDLE) && (awaddr_q == `SFCAL_ADDR_GAIN0))
      begin
         gain_q[0] <= gain0_new[23:0];
      end
      else if (wr_fire && (state_q == SFCAL_IDLE) && (awaddr_q == `SFCAL_ADDR_GAIN1))
      begin
         gain_q[1] <= gain1_new[23:0];
      end
   end

   // ======================================================================
   // Conversions, never during calibration, so calibration leaves data alone.
   assign conv_upd = (state_q == SFCAL_IDLE) && out_tick
                     && ((md == `SFCAL_MD_CONT) || (md == `SFCAL_MD_SINGLE));
   assign prod     = afe_sample * gain_q[mode_q.channel];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         data_q <= `SFCAL_DATA_RST;
      end
      else if (conv_upd)
      begin
         data_q <= prod[`SFCAL_PROD_MSB:`SFCAL_PROD_LSB];
      end
   end

   // ======================================================================
   // Analog front-end control
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !filt_q.chop_enable)
      begin
         chop_ph_q <= 1'b0;
      end
      else if (mod_tick)
      begin
         chop_ph_q <= !chop_ph_q;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         afe_q <= '0;
      end
      else
      begin
         afe_q.pga_range     <= {mode_q.input_range_bit1, mode_q.input_range_bit0};
         afe_q.ac_excitation <= mode_q.ac_excitation_select;
         afe_q.chop_phase    <= chop_ph_q;
         afe_q.channel       <= mode_q.channel;
         afe_q.cal_active    <= (state_q == SFCAL_CAL);
      end
   end
   assign afe_ctl = afe_q;

   // ======================================================================
   // Checks
   property p_cmd_ready;
      @(posedge aclk) disable iff (!aresetn)
      cal_cmd |-> ##[1:MOD_WAIT] (ready_n_q && state_q == SFCAL_CAL);
   endproperty
   a_cmd_ready: assert property (p_cmd_ready) else $error("ready not raised in time");

   property p_done_idle;
      @(posedge aclk) disable iff (!aresetn)
      cal_done |=> (md == `SFCAL_MD_IDLE) && (state_q == SFCAL_IDLE);
   endproperty
   a_done_idle: assert property (p_done_idle) else $error("mode not idle after cal");

   property p_done_ready;
      @(posedge aclk) disable iff (!aresetn)
      cal_done |=> !ready_n;
   endproperty
   a_done_ready: assert property (p_done_ready) else $error("ready not low after cal");

   property p_cal_ready_high;
      @(posedge aclk) disable iff (!aresetn)
      (state_q == SFCAL_CAL) |-> ready_n;
   endproperty
   a_cal_ready_high: assert property (p_cal_ready_high) else $error("ready low in cal");

   property p_cal_len;
      @(posedge aclk) disable iff (!aresetn)
      cal_done |-> (per_cnt_q == (filt_q.chop_enable ? (`SFCAL_CAL_PER_CHOP - 5'h01)
                                                     : (`SFCAL_CAL_PER_NOCHOP - 5'h01)));
   endproperty
   a_cal_len: assert property (p_cal_len) else $error("wrong calibration length");

   property p_data_hold;
      @(posedge aclk) disable iff (!aresetn)
      (state_q == SFCAL_CAL) |=> $stable(data_q);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("data changed in cal");

   property p_other_gain;
      @(posedge aclk) disable iff (!aresetn)
      (cal_done && !mode_q.channel) |=> $stable(gain_q[1]);
   endproperty
   a_other_gain: assert property (p_other_gain) else $error("other gain disturbed");

   property p_range_follow;
      @(posedge aclk) disable iff (!aresetn)
      (state_q == SFCAL_CAL) && $past(state_q == SFCAL_CAL)
         |-> afe_ctl.pga_range == $past({mode_q.input_range_bit1, mode_q.input_range_bit0});
   endproperty
   a_range_follow: assert property (p_range_follow) else $error("gain range mismatch");

   property p_single_idle;
      @(posedge aclk) disable iff (!aresetn)
      (conv_upd && md == `SFCAL_MD_SINGLE && !wr_mode) |=> (md == `SFCAL_MD_IDLE) && !ready_n;
   endproperty
   a_single_idle: assert property (p_single_idle) else $error("single conv not idle");

   property p_limit;
      @(posedge aclk) disable iff (!aresetn)
      (cal_done && afe_sample > fs_limit) |=> range_err_q && $stable(gain_q[0])
                                               && $stable(gain_q[1]);
   endproperty
   a_limit: assert property (p_limit) else $error("over-range point accepted");

endmodule : sfcal_ctrl

// ==== testbench/sfcal_afe_model.sv ====
`timescale 1ns/100ps

// ==========================================================================
// Front end model
module sfcal_afe_model (
   input  wire logic        aclk,
   input  wire logic [23:0] level,
   output logic [23:0]      afe_sample
);
   // The bench moves the level only between calibrations, so it is stable throughout.
   always_ff @(posedge aclk)
      afe_sample <= level;
endmodule : sfcal_afe_model

// ==== testbench/test_system_fullscale_calibration_control.sv ====
`timescale 1ns/100ps
`include "sfcal_defines.svh"

module test_system_fullscale_calibration_control
   import sfcal_pkg::*;
;
   // ========================================================================
   // Signals
   logic           aclk = 1'h0;
   logic           aresetn = 1'h0;
   logic [7:0]     awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]    wdata = 32'h0, rdata;
   logic           awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic           arvalid = 1'h0, rready = 1'h0;
   logic           awready, wready, bvalid, arready, rvalid, ready_n, mclk_out;
   logic [1:0]     bresp, rresp;
   logic [23:0]    lvl = 24'h0, smp;
   sfcal_afe_ctl_t afe_ctl;
   int             errors = 0;
   int             n_tests = 0;

   sfcal_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .afe_sample(smp), .ready_n(ready_n),
      .afe_ctl(afe_ctl), .mclk_out(mclk_out));

   sfcal_afe_model i_afe (.aclk(aclk), .level(lvl), .afe_sample(smp));

   initial
      forever #5 aclk = ~aclk;

   // ========================================================================
   // Shared tasks
   task automatic results();
      if (errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic tmo(input int n, input int lim);
      if (n >= lim)
      begin
         errors++;
         results();
      end
   endtask : tmo

   // Sampling at the falling edge sees what the next rising edge will take.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic ah, wh, bh;
      logic [1:0] br;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      n = 0;
      do
      begin
         @(negedge aclk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         bh = bvalid;
         br = bresp;
         @(posedge aclk);
         if (ah) awvalid <= 1'h0;
         if (wh) wvalid <= 1'h0;
         n++;
      end
      while (!bh && n < 200);
      bready <= 1'h0;
      tmo(n, 200);
      chk("bresp", {30'h0, er}, {30'h0, br});
      // One idle edge keeps a following request off the edge that released bready.
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
      int n;
      logic ah, rh;
      logic [1:0] rr;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      n = 0;
      do
      begin
         @(negedge aclk);
         ah = arvalid && arready;
         rh = rvalid;
         v = rdata;
         rr = rresp;
         @(posedge aclk);
         if (ah) arvalid <= 1'h0;
         n++;
      end
      while (!rh && n < 200);
      rready <= 1'h0;
      tmo(n, 200);
      chk("rresp", {30'h0, er}, {30'h0, rr});
      @(posedge aclk);
   endtask : rd

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, `SFCAL_RESP_OKAY, v);
      chk(nm, exp, v);
   endtask : rchk

   task automatic wt(input logic v, input int lim, output int n);
      n = 0;
      do
      begin
         @(negedge aclk);
         n++;
      end
      while (ready_n !== v && n < lim);
      tmo(n, lim);
      @(posedge aclk);
   endtask : wt

   task automatic do_cal(input logic [31:0] md, input logic chop, input int len);
      int n;
      logic ph;
      wr(`SFCAL_ADDR_FILTER, {31'h1, chop}, `SFCAL_RESP_OKAY);
      wr(`SFCAL_ADDR_MODE, md, `SFCAL_RESP_OKAY);
      wt(1'h1, 40, n);
      chk("ready_rise", 32'h1, {31'h0, n <= 33});
      @(negedge aclk);
      chk("pga_range", {30'h0, md[4:3]}, {30'h0, afe_ctl.pga_range});
      chk("ac_exc", {31'h0, md[5]}, {31'h0, afe_ctl.ac_excitation});
      chk("cal_ch", {31'h0, md[6]}, {31'h0, afe_ctl.channel});
      chk("cal_act", 32'h1, {31'h0, afe_ctl.cal_active});
      @(posedge aclk);
      wt(1'h0, 1000, n);
      chk("cal_len", len, (n + 2 >= len - 2 && n + 2 <= len + 2) ? len : n + 2);
      rchk("mode_idle", `SFCAL_ADDR_MODE, md & 32'h78);
      // With chop enabled, any window of one modulator cycle holds exactly one chop toggle; with chop off, none.
      @(negedge aclk);
      ph = afe_ctl.chop_phase;
      repeat (32) @(negedge aclk);
      chk("chop_ph", {31'h0, chop ? !ph : ph}, {31'h0, afe_ctl.chop_phase});
      @(posedge aclk);
   endtask : do_cal

   // ========================================================================
   // Scenarios
   task automatic t_reset();
      logic [31:0] v;
      rchk("mode_rst", `SFCAL_ADDR_MODE, 32'h0);
      rchk("filter_rst", `SFCAL_ADDR_FILTER, 32'h21);
      rchk("gain0_rst", `SFCAL_ADDR_GAIN0, 32'h800000);
      rchk("gain1_rst", `SFCAL_ADDR_GAIN1, 32'h800000);
      rd(8'h18, `SFCAL_RESP_SLVERR, v);
      chk("unmapped", 32'h0, v);
      @(negedge aclk);
      chk("ready_rst", 32'h1, {31'h0, ready_n});
      chk("mclk_lo", 32'h0, {31'h0, mclk_out});
      #6;
      chk("mclk_hi", 32'h1, {31'h0, mclk_out});
      @(posedge aclk);
   endtask : t_reset

   task automatic t_conv(input logic [23:0] s, input logic [23:0] g);
      logic [31:0] v;
      logic [47:0] p;
      int n;
      lvl <= s;
      wr(`SFCAL_ADDR_FILTER, 32'h3, `SFCAL_RESP_OKAY);
      wr(`SFCAL_ADDR_MODE, 32'h2, `SFCAL_RESP_OKAY);
      n = 0;
      do
      begin
         rd(`SFCAL_ADDR_MODE, `SFCAL_RESP_OKAY, v);
         n++;
      end
      while (v[2:0] !== 3'h0 && n < 60);
      tmo(n, 60);
      p = s * g;
      rchk("data", `SFCAL_ADDR_DATA, {8'h0, p[46:23]});
      chk("ready_conv", 32'h0, {31'h0, ready_n});
   endtask : t_conv

   task automatic t_cal_chop();
      lvl <= 24'd50000;
      do_cal(32'h1F, 1'h1, 22 * 32);
      rchk("gain0_cal", `SFCAL_ADDR_GAIN0, 32'd50000);
      rchk("gain1_kept", `SFCAL_ADDR_GAIN1, 32'h800000);
      rchk("data_kept", `SFCAL_ADDR_DATA, 32'd1234);
   endtask : t_cal_chop

   task automatic t_cal_refuse();
      logic [31:0] v;
      lvl <= 24'd20000;
      do_cal(32'h67, 1'h0, 24 * 32);
      rchk("gain1_refused", `SFCAL_ADDR_GAIN1, 32'h800000);
      rd(`SFCAL_ADDR_STATUS, `SFCAL_RESP_OKAY, v);
      chk("range_err", 32'h1, {31'h0, v[1]});
   endtask : t_cal_refuse

   // Continuous mode keeps converting and never returns to idle by itself.
   task automatic t_cont(input logic [23:0] s, input logic [31:0] exp);
      lvl <= s;
      wr(`SFCAL_ADDR_MODE, 32'h1, `SFCAL_RESP_OKAY);
      repeat (80) @(posedge aclk);
      rchk("cont_mode", `SFCAL_ADDR_MODE, 32'h1);
      rchk("cont_data", `SFCAL_ADDR_DATA, exp);
      wr(`SFCAL_ADDR_MODE, 32'h0, `SFCAL_RESP_OKAY);
   endtask : t_cont

   // ========================================================================
   // Main sequence
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_reset();
      t_conv(24'd1234, 24'h800000);
      // The model front end has no offset, so its zero-scale point counts as
      // valid, and the bench clock is stable from time zero.
      t_cal_chop();
      t_cal_refuse();
      t_conv(24'h100000, 24'd50000);
      t_cont(24'h800000, 32'd50000);
      results();
   end
endmodule : test_system_fullscale_calibration_control
